//--- hdl/eirq_top.sv
// Contract
// - in transfer-peripheral mode a channel's flag clears after one item.
// - a read-modify-write read of the cause flags returns all ones.
// - request n is high only while enable bit n and flag n are both 1.
// - enable bits 7..4 and detect bits 15..8 have no effect.
// - a detection match sets the flag whatever the enable bit.
// - the pin levels stay readable regardless of the enables.
// - channels map to interrupt numbers 16, 13 and 11 (ch2 unconfirmed).
// - detect field n sits at bits 2n+1 and 2n.
// - writing 0 to a flag clears it, writing 1 leaves it.
// - cause flags sit at bits 11..8, enables in the low byte.
//
// Purpose: four-channel external interrupt detector with AHB-Lite regs
// Assumes: pins synchronous to sys_clk; single word transfers
// Notes:   zero-wait-state slave, response always OKAY
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "eirq_params.svh"
module eirq_top
  import eirq_pkg::*;
#(
  parameter int NCH = `EIRQ_NCH
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins and transfer service
  input  wire logic [3:0]  ext_irq_pin,
  input  wire logic [3:0]  xfer_done,
  // requests and transfer-peripheral mode
  output logic [3:0]       irq_req,
  output logic [3:0]       transfer_peripheral_mode
);
  // ===================================================================
  // state
  logic [3:0]  irq_cause_reg,  irq_cause_next;
  logic [3:0]  irq_enable_reg, irq_enable_next;
  logic [7:0]  detect_condition_reg, detect_condition_next;
  logic [3:0]  dtp_reg, dtp_next;
  logic [3:0]  irq_req_reg, irq_req_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        wr_pend_reg, wr_pend_next;
  logic [11:0] wr_addr_reg, wr_addr_next;
  logic        hreadyout_reg, hreadyout_next;
  logic        hresp_reg, hresp_next;
  logic [3:0]  hit;
  logic        rd_take;
  logic        wr_take;

  // ===================================================================
  // per-channel detectors
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      eirq_detect_ch u_det (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (ext_irq_pin[g]),
        .mode    (detect_condition_reg[2*g+1:2*g]),
        .hit     (hit[g])
      );
    end
  endgenerate

  // ===================================================================
  // bus decode
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  // ===================================================================
  // next-state logic
  always_comb begin
    irq_cause_next        = irq_cause_reg;
    irq_enable_next       = irq_enable_reg;
    detect_condition_next = detect_condition_reg;
    dtp_next              = dtp_reg;
    wr_pend_next          = wr_take;
    wr_addr_next          = wr_take ? haddr : wr_addr_reg;
    hrdata_next           = 32'h0000_0000;
    hreadyout_next        = 1'b1;
    hresp_next            = 1'b0;
    if (wr_pend_reg) begin
      if (wr_addr_reg == `EIRQ_OFS_CAUSE_EN) begin
        irq_enable_next = hwdata[3:0];
        irq_cause_next  = irq_cause_reg & hwdata[11:8];
      end else if (wr_addr_reg == `EIRQ_OFS_CAUSE_RMW) begin
        irq_cause_next  = irq_cause_reg & hwdata[11:8];
      end else if (wr_addr_reg == `EIRQ_OFS_DETECT) begin
        detect_condition_next = hwdata[7:0];
      end else if (wr_addr_reg == `EIRQ_OFS_DTP_MODE) begin
        dtp_next = hwdata[3:0];
      end
    end
    irq_cause_next = irq_cause_next & ~(dtp_reg & xfer_done);
    irq_cause_next = irq_cause_next | hit;
    if (rd_take) begin
      if (haddr == `EIRQ_OFS_CAUSE_EN) begin
        hrdata_next = {20'h00000, irq_cause_reg, 4'h0,
                       irq_enable_reg};
      end else if (haddr == `EIRQ_OFS_CAUSE_RMW) begin
        hrdata_next = {20'h00000, 4'hF, 4'h0, irq_enable_reg};
      end else if (haddr == `EIRQ_OFS_DETECT) begin
        hrdata_next = {24'h000000, detect_condition_reg};
      end else if (haddr == `EIRQ_OFS_PORT_VAL) begin
        hrdata_next = {28'h0000000, ext_irq_pin};
      end else if (haddr == `EIRQ_OFS_DTP_MODE) begin
        hrdata_next = {28'h0000000, dtp_reg};
      end
    end
    irq_req_next = irq_cause_next & irq_enable_next;
  end

  // ===================================================================
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_cause_reg        <= 4'h0;
      irq_enable_reg       <= `EIRQ_EN_RESET;
      detect_condition_reg <= `EIRQ_DET_RESET;
      dtp_reg              <= 4'h0;
      irq_req_reg          <= 4'h0;
      hrdata_reg           <= 32'h0000_0000;
      wr_pend_reg          <= 1'b0;
      wr_addr_reg          <= 12'h000;
      hreadyout_reg        <= 1'b1;
      hresp_reg            <= 1'b0;
    end else begin
      irq_cause_reg        <= irq_cause_next;
      irq_enable_reg       <= irq_enable_next;
      detect_condition_reg <= detect_condition_next;
      dtp_reg              <= dtp_next;
      irq_req_reg          <= irq_req_next;
      hrdata_reg           <= hrdata_next;
      wr_pend_reg          <= wr_pend_next;
      wr_addr_reg          <= wr_addr_next;
      hreadyout_reg        <= hreadyout_next;
      hresp_reg            <= hresp_next;
    end
  end

  // ===================================================================
  // outputs; request n goes to the fixed interrupt number in the params header
  assign irq_req                  = irq_req_reg;
  assign transfer_peripheral_mode = dtp_reg;
  assign hrdata                   = hrdata_reg;
  assign hreadyout                = hreadyout_reg;
  assign hresp                    = hresp_reg;

  // ===================================================================
  // checks
  chk_req_gate: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    irq_req == (irq_cause_reg & irq_enable_reg))
    else $error("request not flag and enable");

  chk_flag_set: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    hit[0] |=> irq_cause_reg[0])
    else $error("match did not set flag");

  chk_dtp_clear: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (dtp_reg[1] && xfer_done[1] && !hit[1]) |=> !irq_cause_reg[1])
    else $error("transfer did not clear flag");

  chk_rmw_ones: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rd_take && haddr == `EIRQ_OFS_CAUSE_RMW) |=> hrdata[11:8] == 4'hF)
    else $error("rmw read not all ones");

  chk_write_clear: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_pend_reg && wr_addr_reg == `EIRQ_OFS_CAUSE_EN && !hwdata[8]
     && !hit[0]) |=> !irq_cause_reg[0])
    else $error("write zero did not clear");

  chk_write_keep: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_pend_reg && irq_cause_reg[2] && hwdata[10]
     && !(dtp_reg[2] && xfer_done[2])) |=> irq_cause_reg[2])
    else $error("write one changed flag");

  chk_pin_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rd_take && haddr == `EIRQ_OFS_PORT_VAL)
    |=> hrdata[3:0] == $past(ext_irq_pin))
    else $error("pin read wrong");

  chk_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    hrdata[31:12] == 20'h00000 && hrdata[7:4] == 4'h0)
    else $error("unimplemented bits visible");

  chk_rise_edge: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ($past(nrst) && detect_condition_reg[7:6] == 2'b10 && ext_irq_pin[3]
     && !$past(ext_irq_pin[3])) |-> hit[3])
    else $error("rising edge missed");

  chk_det_write: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_pend_reg && wr_addr_reg == `EIRQ_OFS_DETECT)
    |=> detect_condition_reg == $past(hwdata[7:0]))
    else $error("detect write wrong");

  chk_en_write: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_pend_reg && wr_addr_reg == `EIRQ_OFS_CAUSE_EN)
    |=> irq_enable_reg == $past(hwdata[3:0]))
    else $error("enable write wrong");

  chk_rmw_en_keep: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_pend_reg && wr_addr_reg == `EIRQ_OFS_CAUSE_RMW)
    |=> irq_enable_reg == $past(irq_enable_reg))
    else $error("rmw write changed enables");

  chk_cause_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rd_take && haddr == `EIRQ_OFS_CAUSE_EN)
    |=> (hrdata[11:8] == $past(irq_cause_reg)
         && hrdata[3:0] == $past(irq_enable_reg)))
    else $error("cause read wrong");

  chk_det_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rd_take && haddr == `EIRQ_OFS_DETECT)
    |=> hrdata[7:0] == $past(detect_condition_reg))
    else $error("detect read wrong");

  chk_dtp_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rd_take && haddr == `EIRQ_OFS_DTP_MODE)
    |=> hrdata[3:0] == $past(dtp_reg))
    else $error("mode read wrong");

  chk_idle_zero: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !rd_take |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  chk_bus_okay: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");

  chk_dtp_out: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    transfer_peripheral_mode == dtp_reg)
    else $error("mode output wrong");

  // ===================================================================
  // per-channel checks
  generate
    for (g = 0; g < NCH; g++) begin : gen_chk
      chk_ch_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        hit[g] |=> irq_cause_reg[g])
        else $error("channel match did not set flag");

      chk_ch_dtp: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (dtp_reg[g] && xfer_done[g] && !hit[g])
        |=> !irq_cause_reg[g])
        else $error("channel transfer did not clear flag");

      chk_ch_req: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        irq_req[g] |-> (irq_cause_reg[g] && irq_enable_reg[g]))
        else $error("channel request without flag and enable");

      chk_ch_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!hit[g] && !wr_pend_reg && !(dtp_reg[g] && xfer_done[g]))
        |=> irq_cause_reg[g] == $past(irq_cause_reg[g]))
        else $error("channel flag changed by itself");

      chk_ch_wclr: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (wr_pend_reg && (wr_addr_reg == `EIRQ_OFS_CAUSE_EN
                         || wr_addr_reg == `EIRQ_OFS_CAUSE_RMW)
         && !hwdata[8+g] && !hit[g]) |=> !irq_cause_reg[g])
        else $error("channel write zero did not clear");

      chk_ch_wkeep: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (wr_pend_reg && irq_cause_reg[g] && hwdata[8+g]
         && !(dtp_reg[g] && xfer_done[g])) |=> irq_cause_reg[g])
        else $error("channel write one changed flag");

      chk_ch_low: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (detect_condition_reg[2*g+1:2*g] == 2'b00 && !ext_irq_pin[g])
        |=> irq_cause_reg[g])
        else $error("low level missed");

      chk_ch_high: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (detect_condition_reg[2*g+1:2*g] == 2'b01 && ext_irq_pin[g])
        |=> irq_cause_reg[g])
        else $error("high level missed");

      chk_ch_rise: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ($past(nrst) && detect_condition_reg[2*g+1:2*g] == 2'b10
         && ext_irq_pin[g] && !$past(ext_irq_pin[g]))
        |=> irq_cause_reg[g])
        else $error("channel rising edge missed");

      chk_ch_fall: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ($past(nrst) && detect_condition_reg[2*g+1:2*g] == 2'b11
         && !ext_irq_pin[g] && $past(ext_irq_pin[g]))
        |=> irq_cause_reg[g])
        else $error("channel falling edge missed");
    end
  endgenerate
endmodule : eirq_top

//--- hdl/eirq_params.svh
// Purpose: constants for the external interrupt detector
// Assumes: 32-bit AHB-Lite register words
// Notes:   offsets chosen for this block
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH
// =====================================================================
// register offsets
`define EIRQ_OFS_CAUSE_EN   12'h000
`define EIRQ_OFS_DETECT     12'h004
`define EIRQ_OFS_PORT_VAL   12'h008
`define EIRQ_OFS_DTP_MODE   12'h00C
`define EIRQ_OFS_CAUSE_RMW  12'h010
// =====================================================================
// fields and reset values
`define EIRQ_CAUSE_LSB      8
`define EIRQ_NCH            4
`define EIRQ_EN_RESET       4'h0
`define EIRQ_DET_RESET      8'h00
// =====================================================================
// interrupt numbers
`define EIRQ_IRQNUM_CH3     8'h10
`define EIRQ_IRQNUM_CH2     8'h10
`define EIRQ_IRQNUM_CH1     8'h0D
`define EIRQ_IRQNUM_CH0     8'h0B
`endif

//--- hdl/eirq_pkg.sv
// Purpose: types for the external interrupt detector
// Assumes: nothing
// Notes:   detection mode encoding
package eirq_pkg;
  // ===================================================================
  // detection modes
  typedef enum logic [1:0] {
    EIRQ_LOW_LEVEL,
    EIRQ_HIGH_LEVEL,
    EIRQ_RISE_EDGE,
    EIRQ_FALL_EDGE
  } eirq_mode_e;
endpackage : eirq_pkg

//--- hdl/eirq_detect_ch.sv
// Purpose: one-channel level/edge detector
// Assumes: pin synchronous to sys_clk
// Notes:   hit is combinational from the pin and the registered previous level
`timescale 1ns/10ps
`include "eirq_params.svh"
module eirq_detect_ch
  import eirq_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // pin and mode
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  // result
  output logic            hit
);
  logic prev_reg;
  logic prev_next;

  // ===================================================================
  // previous level
  always_comb begin
    prev_next = pin;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // ===================================================================
  // mode decode
  always_comb begin
    case (eirq_mode_e'(mode))
      EIRQ_LOW_LEVEL:  hit = !pin;
      EIRQ_HIGH_LEVEL: hit = pin;
      EIRQ_RISE_EDGE:  hit = pin && !prev_reg;
      default:         hit = !pin && prev_reg;
    endcase
  end
endmodule : eirq_detect_ch

//--- tb/eirq_periph_model.sv
// Purpose: external peripherals driving the interrupt pins
// Assumes: wanted levels come from the bench
// Notes:   each new level is held four cycles unless xfer_done forces the pin low
`timescale 1ns/10ps
module eirq_periph_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // wanted levels and transfer completion
  input  wire logic [3:0] want,
  input  wire logic [3:0] xfer_done,
  // pin drive
  output logic [3:0]      pin
);
  // ===================================================================
  // pin drivers; pins act as inputs of the block
  logic [1:0] hold_reg [4];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin <= 4'h0;
      for (int c = 0; c < 4; c++) hold_reg[c] <= 2'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (xfer_done[c]) begin
          pin[c]      <= 1'b0;
          hold_reg[c] <= 2'h3;
        end else if (pin[c] != want[c] && hold_reg[c] == 2'h0) begin
          pin[c]      <= want[c];
          hold_reg[c] <= 2'h3;
        end else if (hold_reg[c] != 2'h0) begin
          hold_reg[c] <= hold_reg[c] - 2'h1;
        end
      end
    end
  end
endmodule : eirq_periph_model

//--- tb/eirq_top_tb.sv
// Purpose: self-checking bench for the external interrupt detector
// Assumes: zero-wait slave, pins driven by the peripheral model
// Notes:   directed sequence of register and pin steps
`timescale 1ns/10ps
`include "eirq_params.svh"
`define CHK(act, exp) begin \
  check_count++; \
  if ((act) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, act, exp); \
  end \
end
module eirq_top_tb
  import eirq_pkg::*;
;
  // ===================================================================
  // signals
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  pins;
  logic [3:0]  want = 4'h0;
  logic [3:0]  xfer_done = 4'h0;
  logic [3:0]  irq_req;
  logic [3:0]  tpm;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          check_count = 0;
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;
  // ===================================================================
  // instances
  eirq_top i_eirq_top (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(pins),
    .xfer_done(xfer_done), .irq_req(irq_req),
    .transfer_peripheral_mode(tpm));
  eirq_periph_model i_eirq_periph_model (.sys_clk(sys_clk), .nrst(nrst),
    .want(want), .xfer_done(xfer_done), .pin(pins));
  // ===================================================================
  // tasks
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : ahb
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ===================================================================
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
  // ===================================================================
  // tests
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'hF0)
    `CHK(hresp, 1'b0)
    ahb(1'b0, `EIRQ_OFS_DETECT, 32'h0);
    `CHK(rd[7:0], `EIRQ_DET_RESET)
    $display("test reset done");
    ahb(1'b1, `EIRQ_OFS_DETECT, 32'h0000_FF00);
    ahb(1'b1, `EIRQ_OFS_CAUSE_EN, 32'h0000_00F0);
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'hF0)
    `CHK(irq_req, 4'h0)
    $display("test unused bits done");
    want = 4'h1;
    settle();
    ahb(1'b1, `EIRQ_OFS_DETECT, 32'h0000_FFE4);
    ahb(1'b1, `EIRQ_OFS_CAUSE_EN, 32'h0);
    ahb(1'b1, `EIRQ_OFS_CAUSE_EN, 32'h0000_0F0F);
    `CHK(irq_req, 4'h0)
    ahb(1'b0, `EIRQ_OFS_PORT_VAL, 32'h0);
    `CHK(rd[3:0], 4'h1)
    want = 4'hE;
    settle();
    `CHK(irq_req, 4'h7)
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'h7F)
    $display("test modes done");
    want = 4'h1;
    settle();
    ahb(1'b1, `EIRQ_OFS_CAUSE_EN, 32'h0000_0D0F);
    `CHK(irq_req, 4'hD)
    ahb(1'b1, `EIRQ_OFS_CAUSE_EN, 32'h0000_0F07);
    `CHK(irq_req, 4'h5)
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'hD7)
    ahb(1'b0, `EIRQ_OFS_CAUSE_RMW, 32'h0);
    `CHK(rd[11:8], 4'hF)
    ahb(1'b1, `EIRQ_OFS_CAUSE_RMW, 32'h0);
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'h07)
    $display("test clear done");
    ahb(1'b1, `EIRQ_OFS_DTP_MODE, 32'h0000_0004);
    `CHK(tpm, 4'h4)
    want = 4'h5;
    settle();
    `CHK(irq_req, 4'h4)
    @(posedge sys_clk);
    xfer_done <= 4'h4;
    want      <= 4'h1;
    @(posedge sys_clk);
    xfer_done <= 4'h0;
    settle();
    `CHK(irq_req, 4'h0)
    ahb(1'b0, `EIRQ_OFS_CAUSE_EN, 32'h0);
    `CHK({rd[11:8], rd[3:0]}, 8'h07)
    $display("test transfer done");
    stop_test();
  end
endmodule : eirq_top_tb
